// file: core/pcf_pkg.sv
// constants shared by the port configuration block
package pcf_pkg;
	localparam int          NPIN        = 32;
	localparam int          NAD         = 16;
	localparam int          AW          = 6;
	localparam int          DW          = 16;
	// port bases, upper address bits
	localparam logic [1:0]  PORT_AD     = 2'h0;
	localparam logic [1:0]  PORT_M      = 2'h1;
	localparam logic [1:0]  PORT_S      = 2'h2;
	// register field offsets, lower address bits
	localparam logic [3:0]  F_DATA      = 4'h0;
	localparam logic [3:0]  F_INPUT     = 4'h1;
	localparam logic [3:0]  F_DIR       = 4'h2;
	localparam logic [3:0]  F_DRV       = 4'h3;
	localparam logic [3:0]  F_PULL      = 4'h4;
	localparam logic [3:0]  F_POL       = 4'h5;
	localparam logic [3:0]  F_WOM       = 4'h6;
	localparam logic [3:0]  F_IRQEN     = 4'h6;
	localparam logic [3:0]  F_FLAG      = 4'h7;
	localparam logic [3:0]  F_DIE       = 4'h8;
	// reset values, pins 15:0 analog port, 23:16 port m, 31:24 serial port
	localparam logic [31:0] RST_DATA    = 32'h0000_0000;
	localparam logic [31:0] RST_DIR     = 32'h0000_0000;
	localparam logic [31:0] RST_DRV     = 32'h0000_0000;
	localparam logic [31:0] RST_PULL    = 32'hFFF0_0000;
	localparam logic [31:0] RST_POL     = 32'h0000_0000;
	localparam logic [31:0] RST_WOM     = 32'h0000_0000;
	localparam logic [15:0] RST_IRQEN   = 16'h0000;
	localparam logic [15:0] RST_DIE     = 16'h0000;
	localparam logic [31:0] WOM_MASK    = 32'hFFFF_0000;
	// filter timing
	localparam logic [2:0]  FILT_CNT    = 3'h4;
	localparam int          CLK_NS      = 20;
	localparam int          STOP_SMP_NS = 2000;
	localparam int          STOP_DIV    = STOP_SMP_NS / CLK_NS;
	localparam logic [6:0]  STOP_DIV_M1 = 7'(STOP_DIV - 1);
endpackage : pcf_pkg

// file: core/pcf_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module pcf_sync (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	input  wire logic [pcf_pkg::NPIN-1:0] d_in,
	output logic      [pcf_pkg::NPIN-1:0] q_out
);
	import pcf_pkg::*;

	logic [NPIN-1:0] meta;

	// meta feeds only the second stage
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta  <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule : pcf_sync

// file: core/pcf_filt.sv
// per-pin edge glitch filter: four passive then four active samples
`timescale 1ns/1ps
module pcf_filt (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	input  wire logic       sample_in,
	input  wire logic       level_in,
	input  wire logic       rise_in,
	output logic            edge_out,
	output logic [2:0]      count_out
);
	import pcf_pkg::*;

	logic [2:0] pcnt;
	logic       active;

	assign active = (level_in == rise_in);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pcnt      <= '0;
			count_out <= '0;
			edge_out  <= 1'b0;
		end else if (ce_in) begin
			edge_out <= 1'b0;
			if (sample_in) begin
				if (!active) begin
					count_out <= '0;
					if (pcnt != FILT_CNT)
						pcnt <= pcnt + 3'h1;
				end else if (pcnt != FILT_CNT) begin
					// passive samples must be consecutive, an early active one restarts the run
					pcnt <= '0;
				end else begin
					// a pulse of three samples or fewer never raises edge_out here
					if (count_out == FILT_CNT - 3'h1) begin
						edge_out  <= 1'b1;
						pcnt      <= '0;
						count_out <= '0;
					end else begin
						count_out <= count_out + 3'h1;
					end
				end
			end
		end
	end
endmodule : pcf_filt

// file: core/pcf_port.sv
// port pin configuration with filtered edge interrupts on the analog port
`timescale 1ns/1ps
// Overview of operation
// - pull device active only when enabled and pin is input or wired-or.
// - polarity 0 gives pull-up, 1 gives pull-down.
// - on interrupt pins polarity 0 detects falling, 1 rising edges.
// - direction 0 is input, 1 drives the output register bit.
// - reduced-drive bit 0 full strength, 1 reduced strength on outputs.
// - interrupt enable and edge logic exist only on the analog port.
// - analog module enabled disables outputs and forces digital input to 1.
// - every port comes out of reset as an input.
// - all port registers reset asynchronously.
// - reset pull-ups on port m 7:4 and serial port, others floating.
// - sixteen edge pins combine into one shared interrupt request.
// - request raised while any flag and its enable are both set.
// - enabled edge interrupt wakes the processor from wait and stop.
// - in run and wait, pulses of 3 clocks ignored, 4 accepted.
// - in stop, pulses to 3.2 us ignored, 10 us accepted.
// - valid edge needs 4 passive then 4 active samples.
// - filters run on bus clock, in stop on the internal oscillator.
// - oscillator runs in stop only while some pin is enabled and unflagged, counting or not.
// - interrupts work on inputs with input enable set and on outputs.
// - in stop the analog port keeps a wake-up path.
// - data read returns pin when input, register bit when output.
// - reads settle within three cycles after a direction change.
module pcf_port (
	input  wire logic                    mclk_in,
	input  wire logic                    rst_in,
	input  wire logic                    ce_in,
	input  wire logic [pcf_pkg::AW-1:0]  addr_in,
	input  wire logic [pcf_pkg::DW-1:0]  wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [pcf_pkg::DW-1:0]  rdata_out,
	input  wire logic                    analog_en_in,
	input  wire logic                    wait_in,
	input  wire logic                    stop_in,
	input  wire logic [pcf_pkg::NPIN-1:0] pin_in,
	output logic      [pcf_pkg::NPIN-1:0] pin_out,
	output logic      [pcf_pkg::NPIN-1:0] pin_oe_out,
	output logic      [pcf_pkg::NPIN-1:0] pin_weak_out,
	output logic      [pcf_pkg::NPIN-1:0] pin_pull_en_out,
	output logic      [pcf_pkg::NPIN-1:0] pin_pull_dn_out,
	output logic                         irq_out,
	output logic                         wake_out,
	output logic                         rc_run_out
);
	import pcf_pkg::*;

	logic [NPIN-1:0] data;
	logic [NPIN-1:0] dir;
	logic [NPIN-1:0] drive_reduce_bit;
	logic [NPIN-1:0] pull_enable_bit;
	logic [NPIN-1:0] port_polarity_bits;
	logic [NPIN-1:0] wom;
	logic [NAD-1:0]  analog_port_irq_enables;
	logic [NAD-1:0]  analog_port_irq_flags;
	logic [NAD-1:0]  digital_input_enable;
	logic [NPIN-1:0] pin_sync;
	logic [NPIN-1:0] pin_rd;
	logic [NPIN-1:0] ana_mask;
	logic [NAD-1:0]  edge_hit;
	logic [NAD-1:0]  filt_src;
	logic [NAD-1:0]  osc_need;
	logic [2:0]      filt_cnt [NAD];
	logic [6:0]      stop_div;
	logic            stop_tick;
	logic            sample;
	logic [NAD-1:0]  flag_clr;
	logic [NPIN-1:0] next_oe;
	logic [NPIN-1:0] next_pull_en;
	logic [DW-1:0]   next_rdata;
	logic [DW-1:0]   rd_field;

	// write one field of a flat register at the addressed port
	function automatic logic [NPIN-1:0] put(input logic [NPIN-1:0] old,
		input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] f);
		put = old;
		if (a == {PORT_AD, f})
			put[15:0] = d;
		else if (a == {PORT_M, f})
			put[23:16] = d[7:0];
		else if (a == {PORT_S, f})
			put[31:24] = d[7:0];
	endfunction : put

	// pick the addressed port's slice, narrow ports read zero above bit 7
	function automatic logic [DW-1:0] get(input logic [NPIN-1:0] v, input logic [1:0] p);
		get = '0;
		unique case (p)
			PORT_AD: get = v[15:0];
			PORT_M:  get = {8'h00, v[23:16]};
			PORT_S:  get = {8'h00, v[31:24]};
			default: get = '0;
		endcase
	endfunction : get

	pcf_sync u_sync (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.ce_in   (ce_in),
		.d_in    (pin_in),
		.q_out   (pin_sync)
	);

	assign ana_mask = {16'h0000, {NAD{analog_en_in}}};
	// synchronised pins, analog port forced high while the analog module owns it
	assign pin_rd   = pin_sync | ana_mask;

	// configuration registers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			data <= RST_DATA;
			dir  <= RST_DIR;
		end else if (ce_in && wr_in) begin
			data <= put(data, addr_in, wdata_in, F_DATA);
			dir  <= put(dir, addr_in, wdata_in, F_DIR);
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			drive_reduce_bit   <= RST_DRV;
			pull_enable_bit    <= RST_PULL;
			port_polarity_bits <= RST_POL;
			wom                <= RST_WOM;
		end else if (ce_in && wr_in) begin
			drive_reduce_bit   <= put(drive_reduce_bit, addr_in, wdata_in, F_DRV);
			pull_enable_bit    <= put(pull_enable_bit, addr_in, wdata_in, F_PULL);
			port_polarity_bits <= put(port_polarity_bits, addr_in, wdata_in, F_POL);
			// wired-or mode only exists on port m and the serial port
			wom <= put(wom, addr_in, wdata_in, F_WOM) & WOM_MASK;
		end
	end

	// analog-port-only interrupt controls
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			analog_port_irq_enables <= RST_IRQEN;
			digital_input_enable    <= RST_DIE;
		end else if (ce_in && wr_in) begin
			if (addr_in == {PORT_AD, F_IRQEN})
				analog_port_irq_enables <= wdata_in;
			if (addr_in == {PORT_AD, F_DIE})
				digital_input_enable <= wdata_in;
		end
	end

	// filter clocking: every bus clock in run and wait, divided tick in stop
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			stop_div <= '0;
		end else if (ce_in) begin
			if (!stop_in || !rc_run_out || stop_tick)
				stop_div <= '0;
			else
				stop_div <= stop_div + 7'h01;
		end
	end

	assign stop_tick = (stop_div == STOP_DIV_M1);
	// a 2 us sample period puts 4 samples between 3.2 us and 10 us
	assign sample    = stop_in ? (rc_run_out && stop_tick) : 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < NAD; gi++) begin : g_filt
			// outputs watch their own drive level, inputs need the input enable
			assign filt_src[gi] = dir[gi] ? data[gi] :
				(digital_input_enable[gi] ? pin_rd[gi] : 1'b1);
			assign osc_need[gi] = (filt_cnt[gi] <= FILT_CNT) &&
				analog_port_irq_enables[gi] && !analog_port_irq_flags[gi];

			pcf_filt u_filt (
				.mclk_in   (mclk_in),
				.rst_in    (rst_in),
				.ce_in     (ce_in),
				.sample_in (sample),
				.level_in  (filt_src[gi]),
				.rise_in   (port_polarity_bits[gi]),
				.edge_out  (edge_hit[gi]),
				.count_out (filt_cnt[gi])
			);
		end
	endgenerate

	// flags: a new edge in the clearing cycle survives
	assign flag_clr = (ce_in && wr_in && addr_in == {PORT_AD, F_FLAG}) ? wdata_in : '0;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			analog_port_irq_flags <= '0;
		else if (ce_in)
			analog_port_irq_flags <= (analog_port_irq_flags & ~flag_clr) | edge_hit;
	end

	// shared request and wake-up
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out    <= 1'b0;
			wake_out   <= 1'b0;
			rc_run_out <= 1'b0;
		end else if (ce_in) begin
			irq_out    <= |(analog_port_irq_flags & analog_port_irq_enables);
			// registered wake level; this model keeps mclk running through stop
			wake_out   <= (stop_in || wait_in) &&
				|(analog_port_irq_flags & analog_port_irq_enables);
			rc_run_out <= stop_in && |osc_need;
		end
	end

	// pin drive decode
	always_comb begin
		// wired-or pins only ever pull low
		next_oe      = dir & ~(wom & data) & ~ana_mask;
		next_pull_en = pull_enable_bit & (~dir | wom);
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_out         <= '0;
			pin_oe_out      <= '0;
			pin_weak_out    <= '0;
			pin_pull_en_out <= RST_PULL;
			pin_pull_dn_out <= '0;
		end else if (ce_in) begin
			pin_out         <= data;
			pin_oe_out      <= next_oe;
			pin_weak_out    <= drive_reduce_bit & dir;
			pin_pull_en_out <= next_pull_en;
			pin_pull_dn_out <= next_pull_en & port_polarity_bits;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_field   = '0;
		next_rdata = '0;
		unique case (addr_in[3:0])
			F_DATA:  rd_field = get((dir & data) | (~dir & pin_rd), addr_in[5:4]);
			F_INPUT: rd_field = get(pin_rd, addr_in[5:4]);
			F_DIR:   rd_field = get(dir, addr_in[5:4]);
			F_DRV:   rd_field = get(drive_reduce_bit, addr_in[5:4]);
			F_PULL:  rd_field = get(pull_enable_bit, addr_in[5:4]);
			F_POL:   rd_field = get(port_polarity_bits, addr_in[5:4]);
			F_WOM:   rd_field = (addr_in[5:4] == PORT_AD) ? analog_port_irq_enables
				: get(wom, addr_in[5:4]);
			F_FLAG:  rd_field = (addr_in[5:4] == PORT_AD) ? analog_port_irq_flags : '0;
			F_DIE:   rd_field = (addr_in[5:4] == PORT_AD) ? digital_input_enable : '0;
			default: rd_field = '0;
		endcase
		if (rd_in)
			next_rdata = rd_field;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			rdata_out <= '0;
		else if (ce_in)
			rdata_out <= next_rdata;
	end
endmodule : pcf_port

// file: test/pcf_pins.sv
// board side of the pins: external drivers, pull devices and floating lines
`timescale 1ns/1ps
module pcf_pins (
	input  wire logic                     mclk_in,
	input  wire logic [pcf_pkg::NPIN-1:0] drv_in,
	input  wire logic [pcf_pkg::NPIN-1:0] oe_in,
	input  wire logic [pcf_pkg::NPIN-1:0] pull_en_in,
	input  wire logic [pcf_pkg::NPIN-1:0] pull_dn_in,
	input  wire logic [pcf_pkg::NPIN-1:0] ext_val_in,
	input  wire logic [pcf_pkg::NPIN-1:0] ext_en_in,
	output logic      [pcf_pkg::NPIN-1:0] lvl_out
);
	// an undriven, unpulled line toggles so a stale value never looks valid
	logic [31:0] flt = '0;
	always @(posedge mclk_in) begin
		flt <= ~lvl_out;
	end
	assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
		| (~oe_in & ~ext_en_in & pull_en_in & ~pull_dn_in) | (~oe_in & ~ext_en_in & ~pull_en_in & flt);
endmodule : pcf_pins

// file: test/pcf_port_checker.sv
// assertions on the outputs of the port configuration block
`timescale 1ns/1ps
module pcf_port_checker (
	input wire logic                     mclk_in,
	input wire logic                     rst_in,
	input wire logic                     rd_in,
	input wire logic                     wr_in,
	input wire logic [pcf_pkg::DW-1:0]   rdata_out,
	input wire logic                     analog_en_in,
	input wire logic                     wait_in,
	input wire logic                     stop_in,
	input wire logic [pcf_pkg::NPIN-1:0] pin_oe_out,
	input wire logic [pcf_pkg::NPIN-1:0] pin_weak_out,
	input wire logic [pcf_pkg::NPIN-1:0] pin_pull_en_out,
	input wire logic                     irq_out,
	input wire logic                     wake_out,
	input wire logic                     rc_run_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_pull_push_pull: assert property ((pin_pull_en_out[15:0] & pin_oe_out[15:0]) == 16'h0000)
		else $error("pull device on a push-pull output");
	a_drive_reduce_out: assert property (!$past(analog_en_in) |-> (pin_weak_out[15:0] & ~pin_oe_out[15:0]) == 16'h0000)
		else $error("reduced drive on an input pin");
	a_analog_outputs_off: assert property ($past(analog_en_in, 2) && $past(analog_en_in) |-> pin_oe_out[15:0] == 16'h0000)
		else $error("analog port still driving");
	a_wake_cause: assert property (wake_out |-> irq_out)
		else $error("wake without request");
	a_wake_mode: assert property (irq_out && $past(stop_in || wait_in) |-> wake_out)
		else $error("no wake in low-power mode");
	a_rc_stop_only: assert property (rc_run_out |-> $past(stop_in))
		else $error("oscillator running outside stop");
	a_read_one_cycle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
		else $error("read data without read strobe");
	a_flag_holds: assert property (irq_out && !$past(wr_in) |=> irq_out)
		else $error("request dropped without a write");
	c_irq: cover property (irq_out);
	c_wake_stop: cover property (wake_out && $past(stop_in));
	c_rc_run: cover property (rc_run_out);
endmodule : pcf_port_checker
bind pcf_port pcf_port_checker chk_u (.mclk_in, .rst_in, .rd_in, .wr_in, .rdata_out, .analog_en_in, .wait_in,
	.stop_in, .pin_oe_out, .pin_weak_out, .pin_pull_en_out, .irq_out, .wake_out, .rc_run_out);

// file: test/pcf_port_tb.sv
// self-checking bench for the port configuration block
`timescale 1ns/1ps
module pcf_port_tb;
	import pcf_pkg::*;
	logic            mclk_in = 1'b0;
	logic            rst_in = 1'b1;
	logic [AW-1:0]   addr_in = '0;
	logic [DW-1:0]   wdata_in = '0;
	logic            wr_in = 1'b0;
	logic            rd_in = 1'b0;
	logic            analog_en_in = 1'b0;
	logic            wait_in = 1'b0;
	logic            stop_in = 1'b0;
	logic [NPIN-1:0] ext_val = '0;
	logic [NPIN-1:0] ext_en = '0;
	logic [DW-1:0]   rdata_out;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe_out, pin_weak_out, pin_pull_en_out, pin_pull_dn_out;
	logic            irq_out, wake_out, rc_run_out;
	int              mismatches = 0;
	int              total_checks = 0;
	int              i;
	// address, write data, expected read back
	localparam logic [37:0] ROWS [7] = '{{6'h02, 16'h1234, 16'h1234}, {6'h12, 16'hABCD, 16'h00CD},
		{6'h23, 16'h5A5A, 16'h005A}, {6'h04, 16'hFFFF, 16'hFFFF}, {6'h3F, 16'hFFFF, 16'h0000},
		{6'h08, 16'h0F0F, 16'h0F0F}, {6'h16, 16'h00FF, 16'h00FF}};
	always #10 mclk_in = ~mclk_in;
	pcf_port dut_u (.mclk_in, .rst_in, .ce_in(1'b1), .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .analog_en_in,
		.wait_in, .stop_in, .pin_in, .pin_out, .pin_oe_out, .pin_weak_out, .pin_pull_en_out, .pin_pull_dn_out,
		.irq_out, .wake_out, .rc_run_out);
	pcf_pins pins_u (.mclk_in(mclk_in), .drv_in(pin_out), .oe_in(pin_oe_out), .pull_en_in(pin_pull_en_out),
		.pull_dn_in(pin_pull_dn_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .lvl_out(pin_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 chk(32'(rdata_out), 32'(e));
	endtask : rd
	// low-true pulse on analog pin 0, then a settling gap long enough for the filter
	task automatic pulse(input int n);
		ext_val[0] <= 1'b0;
		repeat (n) @(posedge mclk_in);
		ext_val[0] <= 1'b1;
		repeat (12) @(posedge mclk_in);
		#1;
	endtask : pulse
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge mclk_in);
		mismatches++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_in <= 1'b0;
		#1 chk(pin_pull_en_out, RST_PULL);
		chk(pin_oe_out | pin_weak_out, 32'h0);
		for (i = 0; i < 7; i++) begin
			wr(ROWS[i][37:32], ROWS[i][31:16]);
			rd(ROWS[i][37:32], ROWS[i][15:0]);
		end
		wr(6'h02, 16'hFFFF);
		wr(6'h00, 16'hA5C3);
		wr(6'h03, 16'h00F0);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(pin_out[15:0] & pin_oe_out[15:0]), 32'hA5C3);
		chk(32'(pin_weak_out[15:0]), 32'h00F0);
		chk(32'(pin_pull_en_out[15:0]), 32'h0);
		rd(6'h00, 16'hA5C3);
		analog_en_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1 chk(32'(pin_oe_out[15:0]), 32'h0);
		rd(6'h01, 16'hFFFF);
		analog_en_in <= 1'b0;
		wr(6'h12, 16'h0000);
		ext_en[23:16]  <= 8'hFF;
		ext_val[23:16] <= 8'h3C;
		repeat (3) @(posedge mclk_in);
		rd(6'h10, 16'h003C);
		ext_en[23:16] <= 8'h00;
		wr(6'h14, 16'h00FF);
		wr(6'h15, 16'h000F);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(pin_pull_en_out[23:16]), 32'hFF);
		chk(32'(pin_pull_dn_out[23:16] & pin_pull_en_out[23:16]), 32'h0F);
		wr(6'h10, 16'h0000);
		wr(6'h12, 16'h00FF);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(pin_pull_en_out[23:16]), 32'hFF);
		wr(6'h16, 16'h0000);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(pin_pull_en_out[23:16]), 32'h0);
		chk(32'(pin_oe_out[23:16]), 32'hFF);
		wr(6'h02, 16'h0000);
		wr(6'h08, 16'h0001);
		wr(6'h05, 16'h0000);
		wr(6'h06, 16'h0001);
		ext_en[0]  <= 1'b1;
		ext_val[0] <= 1'b1;
		repeat (10) @(posedge mclk_in);
		wr(6'h07, 16'hFFFF);
		pulse(3);
		chk(32'(irq_out), 32'h0);
		pulse(4);
		chk(32'(irq_out), 32'h1);
		rd(6'h07, 16'h0001);
		wait_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(wake_out), 32'h1);
		wait_in <= 1'b0;
		wr(6'h07, 16'h0001);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(irq_out), 32'h0);
		wr(6'h05, 16'h0001);
		pulse(10);
		chk(32'(irq_out), 32'h1);
		wr(6'h07, 16'hFFFF);
		wr(6'h06, 16'h0000);
		pulse(10);
		chk(32'(irq_out), 32'h0);
		rd(6'h07, 16'h0001);
		wr(6'h06, 16'h0001);
		repeat (2) @(posedge mclk_in);
		#1 chk(32'(irq_out), 32'h1);
		wr(6'h07, 16'hFFFF);
		ext_val[0] <= 1'b0;
		repeat (10) @(posedge mclk_in);
		stop_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1 chk(32'(rc_run_out), 32'h1);
		ext_val[0] <= 1'b1;
		for (i = 0; i < 900 && wake_out !== 1'b1; i++) #20;
		chk(32'(wake_out), 32'h1);
		#60 chk(32'(rc_run_out), 32'h0);
		stop_in <= 1'b0;
		@(posedge mclk_in);
		rst_in <= 1'b1;
		#2 chk(pin_pull_en_out, RST_PULL);
		chk({pin_oe_out[30:0], irq_out}, 32'h0);
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		test_done;
	end
endmodule : pcf_port_tb
